// >>> verilog/pec_counter.v
// up, stage and up/down event counters with status; word-memory address for the up and stage counters only
`timescale 1ns/100ps
`include "pec_defines.vh"
module pec_counter (
   input  wire                   clk_sys,
   input  wire                   rst_n,
   input  wire                   up_count_in,
   input  wire                   up_reset_in,
   input  wire [`PEC_VAL_W-1:0]  up_preset,
   input  wire                   stg_count_in,
   input  wire                   stg_reset_cmd,
   input  wire [`PEC_VAL_W-1:0]  stg_preset,
   input  wire                   ud_up_in,
   input  wire                   ud_down_in,
   input  wire                   ud_reset_in,
   input  wire [`PEC_UD_W-1:0]   ud_preset,
   input  wire                   up_ref_compare,
   input  wire                   stg_ref_compare,
   output reg  [`PEC_VAL_W-1:0]  up_value_q,
   output reg                    up_status_q,
   output reg  [`PEC_VAL_W-1:0]  up_value_addr_q,
   output reg  [`PEC_VAL_W-1:0]  up_ref_q,
   output reg  [`PEC_VAL_W-1:0]  stg_value_q,
   output reg                    stg_status_q,
   output reg  [`PEC_VAL_W-1:0]  stg_value_addr_q,
   output reg  [`PEC_VAL_W-1:0]  stg_ref_q,
   output reg  [`PEC_UD_W-1:0]   ud_value_q,
   output reg                    ud_status_q
);
   // inputs come from program logic on this clock: no synchronisers
   reg                   up_prev_q;
   reg                   stg_prev_q;
   reg                   udu_prev_q;
   reg                   udd_prev_q;
   reg [`PEC_VAL_W-1:0]  up_value_d;
   reg [`PEC_VAL_W-1:0]  stg_value_d;
   reg [`PEC_UD_W-1:0]   ud_value_d;
   wire                  up_edge;
   wire                  stg_edge;
   wire                  udu_edge;
   wire                  udd_edge;
   wire                  up_at_max;
   wire                  stg_at_max;
   wire                  ud_at_max;
   wire                  ud_at_zero;
   wire                  up_stat_d;
   wire                  stg_stat_d;
   wire                  ud_stat_d;
   wire [`PEC_VAL_W-1:0] up_addr_d;
   wire [`PEC_VAL_W-1:0] stg_addr_d;
   wire [`PEC_VAL_W-1:0] up_ref_d;
   wire [`PEC_VAL_W-1:0] stg_ref_d;

   assign up_edge  = up_count_in & ~up_prev_q;
   assign stg_edge = stg_count_in & ~stg_prev_q;
   assign udu_edge = ud_up_in & ~udu_prev_q;
   assign udd_edge = ud_down_in & ~udd_prev_q;

   // at the top the count is held, never wrapped
   assign up_at_max  = (up_value_q == `PEC_MAX_UP);
   assign stg_at_max = (stg_value_q == `PEC_MAX_UP);
   assign ud_at_max  = (ud_value_q == `PEC_MAX_UD);
   assign ud_at_zero = (ud_value_q == `PEC_ZERO_UD);

   // status follows the new value, so with a non-zero preset reset clears both together
   assign up_stat_d  = (up_value_d >= up_preset);
   // stage value only falls on reset, so its status holds until then; up/down status also drops on a down count
   assign stg_stat_d = (stg_value_d >= stg_preset);
   assign ud_stat_d  = (ud_value_d >= ud_preset);

   // fixed counter numbers give fixed word addresses
   assign up_addr_d  = `PEC_VAL_BASE
                       + {7'h00, `PEC_NUM_UP};
   assign stg_addr_d = `PEC_VAL_BASE
                       + {7'h00, `PEC_NUM_STG};

   // compare reads the value, anything else reads the status bit
   assign up_ref_d  = up_ref_compare ? up_value_d
                      : {15'h0000, up_stat_d};
   assign stg_ref_d = stg_ref_compare ? stg_value_d
                      : {15'h0000, stg_stat_d};

   always @* begin
      up_value_d = up_value_q;
      if (up_reset_in)
         up_value_d = `PEC_ZERO_VAL;
      else if (up_edge && !up_at_max)
         up_value_d = up_value_q + `PEC_ONE_VAL;
   end

   always @* begin
      stg_value_d = stg_value_q;
      if (stg_reset_cmd)
         stg_value_d = `PEC_ZERO_VAL;
      else if (stg_edge && !stg_at_max)
         stg_value_d = stg_value_q + `PEC_ONE_VAL;
   end

   // the idle count input must be off for the other to count
   // no word address here: the value would span two words
   always @* begin
      ud_value_d = ud_value_q;
      if (ud_reset_in)
         ud_value_d = `PEC_ZERO_UD;
      else if (udu_edge && !ud_down_in && !ud_at_max)
         ud_value_d = ud_value_q + `PEC_ONE_UD;
      else if (udd_edge && !ud_up_in && !ud_at_zero)
         ud_value_d = ud_value_q - `PEC_ONE_UD;
   end

   // one flop group per register (edge flags and outputs), each with its own reset
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         up_prev_q <= 1'b0;
      end else begin
         up_prev_q <= up_count_in;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stg_prev_q <= 1'b0;
      end else begin
         stg_prev_q <= stg_count_in;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         udu_prev_q <= 1'b0;
      end else begin
         udu_prev_q <= ud_up_in;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         udd_prev_q <= 1'b0;
      end else begin
         udd_prev_q <= ud_down_in;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         up_value_q <= `PEC_ZERO_VAL;
      end else begin
         up_value_q <= up_value_d;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stg_value_q <= `PEC_ZERO_VAL;
      end else begin
         stg_value_q <= stg_value_d;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ud_value_q <= `PEC_ZERO_UD;
      end else begin
         ud_value_q <= ud_value_d;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         up_status_q <= 1'b0;
      end else begin
         up_status_q <= up_stat_d;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stg_status_q <= 1'b0;
      end else begin
         stg_status_q <= stg_stat_d;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ud_status_q <= 1'b0;
      end else begin
         ud_status_q <= ud_stat_d;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         up_value_addr_q <= `PEC_ZERO_VAL;
      end else begin
         up_value_addr_q <= up_addr_d;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stg_value_addr_q <= `PEC_ZERO_VAL;
      end else begin
         stg_value_addr_q <= stg_addr_d;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         up_ref_q <= `PEC_ZERO_VAL;
      end else begin
         up_ref_q <= up_ref_d;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stg_ref_q <= `PEC_ZERO_VAL;
      end else begin
         stg_ref_q <= stg_ref_d;
      end
   end
endmodule

// >>> verilog/pec_defines.vh
// constants for the preset event counter block
`ifndef PEC_DEFINES_VH
`define PEC_DEFINES_VH
`define PEC_VAL_W      16
`define PEC_UD_W       32
`define PEC_MAX_UP     16'h270f
`define PEC_MAX_UD     32'h3b9ac9ff
`define PEC_VAL_BASE   16'h03e8
`define PEC_NUM_W      9
`define PEC_NUM_UP     9'h002
`define PEC_NUM_STG    9'h007
`define PEC_NUM_UD     9'h005
`define PEC_ZERO_VAL   16'h0000
`define PEC_ONE_VAL    16'h0001
`define PEC_ZERO_UD    32'h00000000
`define PEC_ONE_UD     32'h00000001
`endif

// >>> tb/pec_ladder.sv
// ladder-side model toggling a count input while enabled
`timescale 1ns/100ps
module pec_ladder (input wire clk_sys, input wire en, output reg cnt_q);
   initial cnt_q = 1'b0;
   always @(negedge clk_sys) cnt_q <= en & ~cnt_q; // idles low between runs
endmodule

// >>> tb/pec_counter_asserts.sv
// assertions on the preset event counter ports
`timescale 1ns/100ps
module pec_counter_asserts (input wire clk_sys, input wire rst_n,
   input wire up_count_in, input wire up_reset_in, input wire stg_count_in,
   input wire stg_reset_cmd, input wire [15:0] up_preset, stg_preset,
   input wire [15:0] up_value_q, up_value_addr_q, stg_value_q,
   input wire [15:0] stg_value_addr_q, input wire up_status_q, stg_status_q);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   up_inc_a: assert property (up_count_in && !$past(up_count_in) &&
      !up_reset_in && up_value_q < 16'h270f |=>
      up_value_q == $past(up_value_q) + 16'h1) else $error("no count");
   up_hold_a: assert property (!up_count_in && !up_reset_in |=>
      $stable(up_value_q)) else $error("stray count");
   up_rst_a: assert property (up_reset_in |=> up_value_q == 16'h0)
      else $error("no clear");
   up_stat_a: assert property (up_status_q == (up_value_q >=
      $past(up_preset))) else $error("up status");
   stg_stat_a: assert property (stg_status_q == (stg_value_q >=
      $past(stg_preset))) else $error("stage status");
   count_cap_a: assert property (up_value_q <= 16'h270f &&
      stg_value_q <= 16'h270f) else $error("over max");
   stg_clr_a: assert property (stg_reset_cmd |=> stg_value_q == 16'h0)
      else $error("stage not cleared");
   addr_fix_a: assert property ($past(rst_n) |->
      up_value_addr_q == 16'h3ea && stg_value_addr_q == 16'h3ef)
      else $error("addr");
   cover property (up_status_q && up_count_in);
   cover property (up_value_q == 16'h270f);
   cover property (stg_reset_cmd && stg_status_q);
endmodule

// >>> tb/pec_counter_tb_top.sv
// self-checking bench for the preset event counter
`timescale 1ns/100ps
module pec_counter_tb_top;
   reg clk_sys = 0, rst_n = 0, up_reset_in = 0, stg_reset_cmd = 0;
   reg ud_up_in = 0, ud_down_in = 0, ud_reset_in = 0, ue = 0, se = 0;
   reg up_ref_compare = 0, stg_ref_compare = 0;
   reg [15:0] up_preset = 16'h3, stg_preset = 16'h3;
   reg [31:0] ud_preset = 32'h0;
   wire up_count_in, stg_count_in, up_status_q, stg_status_q, ud_status_q;
   wire [15:0] up_value_q, up_value_addr_q, up_ref_q, stg_value_q;
   wire [15:0] stg_value_addr_q, stg_ref_q;
   wire [31:0] ud_value_q;
   integer err_total = 0, n_tests = 0;
   pec_ladder u_lu (.clk_sys(clk_sys), .en(ue), .cnt_q(up_count_in));
   pec_ladder u_ls (.clk_sys(clk_sys), .en(se), .cnt_q(stg_count_in));
   pec_counter u_dut (
      .clk_sys          (clk_sys),
      .rst_n            (rst_n),
      .up_count_in      (up_count_in),
      .up_reset_in      (up_reset_in),
      .up_preset        (up_preset),
      .stg_count_in     (stg_count_in),
      .stg_reset_cmd    (stg_reset_cmd),
      .stg_preset       (stg_preset),
      .ud_up_in         (ud_up_in),
      .ud_down_in       (ud_down_in),
      .ud_reset_in      (ud_reset_in),
      .ud_preset        (ud_preset),
      .up_ref_compare   (up_ref_compare),
      .stg_ref_compare  (stg_ref_compare),
      .up_value_q       (up_value_q),
      .up_status_q      (up_status_q),
      .up_value_addr_q  (up_value_addr_q),
      .up_ref_q         (up_ref_q),
      .stg_value_q      (stg_value_q),
      .stg_status_q     (stg_status_q),
      .stg_value_addr_q (stg_value_addr_q),
      .stg_ref_q        (stg_ref_q),
      .ud_value_q       (ud_value_q),
      .ud_status_q      (ud_status_q)
   );
   initial forever #2.5 clk_sys = ~clk_sys;
   task chk(input string n, input [15:0] e, g); n_tests++;
      if (g !== e) begin err_total++;
         $display("MISMATCH %s %h %h", n, e, g); end
   endtask
   task chk32(input string n, input [31:0] e, g); n_tests++;
      if (g !== e) begin err_total++;
         $display("MISMATCH %s %h %h", n, e, g); end
   endtask
   // k whole pulses; enables dropped so both lines end low
   task pls(input u, s, integer k); @(negedge clk_sys); ue <= u; se <= s;
      repeat (2 * k) @(negedge clk_sys); ue <= 0; se <= 0; @(negedge clk_sys);
   endtask
   task t_count; pls(1, 1, 2); chk("uv", 16'h2, up_value_q);
      chk("us", 16'h0, up_status_q); pls(1, 1, 1);
      chk("us", 16'h1, up_status_q); chk("ss", 16'h1, stg_status_q);
      up_ref_compare <= 1; stg_ref_compare <= 1; @(negedge clk_sys);
      chk("rf", 16'h3, up_ref_q); chk("sf", 16'h3, stg_ref_q);
      up_ref_compare <= 0; stg_ref_compare <= 0; @(negedge clk_sys);
      chk("rb", 16'h1, up_ref_q); chk("sb", 16'h1, stg_ref_q);
      chk("ua", 16'h3ea, up_value_addr_q); chk("sa", 16'h3ef, stg_value_addr_q);
      $display("t_count end");
   endtask
   task t_reset; up_reset_in <= 1; pls(1, 1, 2); chk("uv", 16'h0, up_value_q);
      chk("us", 16'h0, up_status_q);
      chk("sv", 16'h5, stg_value_q); chk("ss", 16'h1, stg_status_q);
      up_reset_in <= 0; stg_reset_cmd <= 1; @(negedge clk_sys); stg_reset_cmd <= 0;
      chk("sv", 16'h0, stg_value_q); chk("ss", 16'h0, stg_status_q);
      $display("t_reset end");
   endtask
   task t_sat; pls(1, 0, 10000); chk("uv", 16'h270f, up_value_q);
      up_reset_in <= 1; @(negedge clk_sys); up_reset_in <= 0;
      chk("uv", 16'h0, up_value_q); $display("t_sat end");
   endtask
   // up/down: two ups, one down, both together ignored, reset, down at zero
   task t_updown; ud_preset <= 32'h2; ud_up_in <= 1; @(negedge clk_sys);
      ud_up_in <= 0; @(negedge clk_sys); ud_up_in <= 1; @(negedge clk_sys);
      ud_up_in <= 0; @(negedge clk_sys);
      chk32("dv", 32'h2, ud_value_q); chk("ds", 16'h1, ud_status_q);
      ud_down_in <= 1; @(negedge clk_sys); ud_down_in <= 0; @(negedge clk_sys);
      chk32("dv", 32'h1, ud_value_q); chk("ds", 16'h0, ud_status_q);
      ud_up_in <= 1; ud_down_in <= 1; @(negedge clk_sys);
      ud_up_in <= 0; ud_down_in <= 0; @(negedge clk_sys);
      chk32("dv", 32'h1, ud_value_q);
      ud_reset_in <= 1; @(negedge clk_sys); ud_reset_in <= 0;
      chk32("dv", 32'h0, ud_value_q);
      ud_down_in <= 1; @(negedge clk_sys); ud_down_in <= 0; @(negedge clk_sys);
      chk32("dv", 32'h0, ud_value_q);
      $display("t_updown end");
   endtask
   task print_verdict; $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin repeat (8) @(negedge clk_sys); rst_n = 1;
      t_count; t_reset; t_sat; t_updown; print_verdict;
   end
endmodule
bind pec_counter pec_counter_asserts u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
   .up_count_in(up_count_in), .up_reset_in(up_reset_in),
   .stg_count_in(stg_count_in), .stg_reset_cmd(stg_reset_cmd),
   .up_preset(up_preset), .stg_preset(stg_preset),
   .up_value_q(up_value_q), .up_value_addr_q(up_value_addr_q),
   .stg_value_q(stg_value_q), .stg_value_addr_q(stg_value_addr_q),
   .up_status_q(up_status_q), .stg_status_q(stg_status_q));
